/* tb/bes_chk.sv */
// port checker of the boot entry select block
`timescale 1ns/1ns
module bes_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [15:0] boot_addr_o,
  input wire logic [1:0] boot_target_o,
  input wire logic boot_valid_o,
  input wire logic [15:0] boot_map_lo_o,
  input wire logic [15:0] boot_map_hi_o,
  input wire logic [7:0] pll_mult_o,
  input wire logic xtal_bad_o,
  input wire logic [3:0] usb_ep_o,
  input wire logic [7:0] usb_max_pkt_o
);
  // ****
  // properties, all on the one clock
  // ****
  default clocking bes_cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ep; usb_ep_o == 4'h0 && usb_max_pkt_o == 8'h20; endproperty
  a_ep: assert property (p_ep) else $error("endpoint setting wrong");
  property p_map; boot_map_lo_o == 16'hF800 && boot_map_hi_o == 16'hFFFF; endproperty
  a_map: assert property (p_map) else $error("boot map window wrong");
  property p_isp; boot_valid_o && boot_target_o == 2'h2 |-> boot_addr_o == 16'hFF00; endproperty
  a_isp: assert property (p_isp) else $error("loader start wrong");
  property p_user;
    boot_valid_o && boot_target_o == 2'h1 |-> boot_addr_o[7:0] == 8'h00 && boot_addr_o < 16'hF800;
  endproperty
  a_user: assert property (p_user) else $error("user loader start wrong");
  property p_app; boot_valid_o && boot_target_o == 2'h0 |-> boot_addr_o == 16'h0000; endproperty
  a_app: assert property (p_app) else $error("application start wrong");
  property p_hold;
    boot_valid_o |=> boot_valid_o && $stable(boot_addr_o) && $stable(boot_target_o);
  endproperty
  a_hold: assert property (p_hold) else $error("decision moved after reset");
  property p_decide; !boot_valid_o |-> ##[1:6] boot_valid_o; endproperty
  a_decide: assert property (p_decide) else $error("no boot decision");
  property p_rd; !reg_rd_i |=> reg_rdata_o == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data outside read slot");
  property p_bad; xtal_bad_o |-> pll_mult_o == 8'h00; endproperty
  a_bad: assert property (p_bad) else $error("pll set for bad crystal");
  c_isp: cover property (boot_valid_o && boot_target_o == 2'h2);
  c_user: cover property (boot_valid_o && boot_target_o == 2'h1);
  c_app: cover property (boot_valid_o && boot_target_o == 2'h0);
endmodule : bes_chk

/* tb/bes_pin_model.sv */
// board side: drives straps and port pins around reset release
`timescale 1ns/1ns
module bes_pin_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] strap_req_i,
  input wire logic [17:0] port_req_i,
  output logic external_access_strap_o,
  output logic program_store_strobe_o,
  output logic [17:0] port_o
);
  logic [2:0] cnt_r = 3'h0;
  logic [19:0] wnd_r = 20'h0;
  // edges since release; pins held six, past the decision edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) cnt_r <= 3'h0;
    else if (cnt_r != 3'h7) cnt_r <= cnt_r + 3'h1;
  end
  // released pins wander every cycle so a late sample cannot hide
  always_ff @(posedge clk_i) wnd_r <= {~wnd_r[19:18], 18'($urandom)};
  assign {external_access_strap_o, program_store_strobe_o, port_o} =
    (cnt_r < 3'h6) ? {strap_req_i, port_req_i} : wnd_r;
endmodule : bes_pin_model

/* tb/boot_entry_select_tb.sv */
// self-checking bench of the boot entry select block
`timescale 1ns/1ns
module boot_entry_select_tb;
  typedef struct { string name; logic [17:0] val; } bes_note_t;
  logic clk_i = 1'b0, rst_n_i = 1'b0, hpc = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic valid_q = 1'b0;
  logic [1:0] strap = 2'h0;
  logic [17:0] preq = 18'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdat = 8'h0;
  logic [7:0] rv [8] = '{8'hFE, 8'hFF, 8'hFF, 8'h12, 8'hFF, 8'hBF, 8'h0C, 8'h00};
  int xt [9] = '{6, 8, 12, 16, 20, 24, 32, 40, 48};
  logic ea, program_store_strobe, valid, bmap, x2, ok, bad, en;
  logic [17:0] pins;
  logic [7:0] rdata, mult, div, p1;
  logic [15:0] baddr;
  logic [1:0] tgt;
  bes_note_t notes[$];
  bes_note_t nt;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  bes_pin_model pin_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .strap_req_i(strap), .port_req_i(preq),
    .external_access_strap_o(ea), .program_store_strobe_o(program_store_strobe), .port_o(pins));
  bes_boot_entry_select #(.PLL_LOCK_CYC(10)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .high_pin_count_i(hpc), .external_access_strap_i(ea), .program_store_strobe_i(program_store_strobe),
    .port_one_i(pins[7:0]), .port_three_i(pins[15:8]), .port_four_i(pins[17:16]),
    .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .boot_addr_o(baddr), .boot_target_o(tgt), .boot_valid_o(valid), .boot_map_o(bmap),
    .boot_map_lo_o(), .boot_map_hi_o(), .x2_mode_o(x2), .pll_mult_o(mult), .pll_div_o(div),
    .pll_en_o(en), .usb_clk_ok_o(ok), .xtal_bad_o(bad), .usb_ep_o(), .usb_max_pkt_o());
  // ****
  // tasks
  // ****
  task chk(input string n, input logic [17:0] e, input logic [17:0] s);
    n_tests++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      n_fail++;
    end
  endtask : chk
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    wr <= 1'b1; rd <= 1'b0; addr <= a; wdat <= d;
    @(posedge clk_i);
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, input logic [7:0] e);
    rd <= 1'b1; wr <= 1'b0; addr <= a;
    notes.push_back('{"register read", {10'h0, e}});
    @(posedge clk_i);
  endtask : rd_reg
  task idle(input int n);
    wr <= 1'b0; rd <= 1'b0;
    repeat (n) @(posedge clk_i);
  endtask : idle
  // two config writes land before the decision edge four after release
  task boot(input logic h, input logic [1:0] s, input logic [17:0] p, input logic [3:0] a1,
            input logic [7:0] d1, input logic [3:0] a2, input logic [7:0] d2,
            input logic [17:0] e);
    rst_n_i <= 1'b0; hpc <= h; strap <= s; preq <= p;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wr_reg(a1, d1);
    wr_reg(a2, d2);
    notes.push_back('{"boot decision", e});
    idle(10);
  endtask : boot
  // ****
  // clock, timeout and result watcher
  // ****
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    rd_q <= rd;
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      stop_test;
    end
  end
  // read data stand one cycle after the strobe; a decision shows as a rise
  always @(negedge clk_i) begin
    if (rd_q || (valid === 1'b1 && valid_q !== 1'b1)) begin
      if (notes.size() == 0) chk("spare result", 18'h0, 18'h1);
      else begin
        nt = notes.pop_front();
        chk(nt.name, nt.val, rd_q ? {10'h0, rdata} : {tgt, baddr});
      end
    end
    valid_q = valid;
  end
  // ****
  // scenarios
  // ****
  initial begin
    void'($urandom(32'h62AE));
    p1 = 8'($urandom) | 8'h01;
    boot(1'b1, 2'b10, {10'h0, 8'hFE}, 4'h3, 8'h12, 4'hF, 8'h00, {2'h2, 16'hFF00});
    chk("boot map", 18'h1, {17'h0, bmap});
    for (int i = 0; i < 8; i++) rd_reg(i == 7 ? 4'hF : 4'(i), rv[i]);
    rd_reg(4'h7, 8'h0E);
    rd_reg(4'h8, 8'hFF);
    wr_reg(4'h2, 8'hA6);
    rd_reg(4'h2, 8'hA6);
    idle(2);
    boot(1'b1, 2'b11, {10'h0, 8'hFE}, 4'h3, 8'h12, 4'hF, 8'h00, {2'h1, 16'h1200});
    boot(1'b0, 2'b10, {10'h0, 8'hFE}, 4'hF, 8'h00, 4'hF, 8'h00, {2'h2, 16'hFF00});
    boot(1'b0, 2'b10, {10'h0, p1}, 4'h3, 8'h34, 4'hF, 8'h00, {2'h1, 16'h3400});
    boot(1'b0, 2'b00, {2'h0, 8'hA5, p1}, 4'h1, 8'hA5, 4'h3, 8'h12, {2'h2, 16'hFF00});
    boot(1'b0, 2'b00, {2'h0, 8'hA4, p1}, 4'h1, 8'hA5, 4'h3, 8'h12, {2'h1, 16'h1200});
    boot(1'b0, 2'b00, {2'h2, 8'h00, p1}, 4'h2, 8'hFE, 4'h3, 8'h12, {2'h2, 16'hFF00});
    boot(1'b0, 2'b00, {10'h0, p1}, 4'hF, 8'h00, 4'hF, 8'h00, {2'h2, 16'hFF00});
    boot(1'b0, 2'b00, {10'h0, p1}, 4'h4, 8'h00, 4'h5, 8'hFF, {2'h0, 16'h0000});
    chk("boot map", 18'h0, {17'h0, bmap});
    for (int m = 0; m < 2; m++) begin
      wr_reg(4'h5, m ? 8'h3F : 8'hBF);
      idle(2);
      chk("double speed", 18'(m), {17'h0, x2});
      foreach (xt[i]) begin
        wr_reg(4'h6, 8'(xt[i]));
        idle(3);
        for (int k = 0; k < 40 && ok !== 1'b1; k++) @(posedge clk_i);
        chk("usb clock ready", 18'h1, {17'h0, ok});
        chk("pll ratio", 18'(48 * div), 18'(xt[i] * mult));
        chk("pll enable", 18'h1, {17'h0, en});
      end
    end
    wr_reg(4'h6, 8'h07);
    idle(3);
    chk("crystal refused", 18'h1, {17'h0, bad});
    chk("pll enable", 18'h0, {17'h0, en});
    chk("usb clock ready", 18'h0, {17'h0, ok});
    chk("notes left", 18'h0, 18'(notes.size()));
    stop_test;
  end
endmodule : boot_entry_select_tb

bind bes_boot_entry_select bes_chk chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .boot_addr_o(boot_addr_o),
  .boot_target_o(boot_target_o), .boot_valid_o(boot_valid_o),
  .boot_map_lo_o(boot_map_lo_o), .boot_map_hi_o(boot_map_hi_o), .pll_mult_o(pll_mult_o),
  .xtal_bad_o(xtal_bad_o), .usb_ep_o(usb_ep_o), .usb_max_pkt_o(usb_max_pkt_o));

/* verilog/bes_boot_entry_select.sv */
// boot entry select: straps, port conditions, boot vector and usb clock setup
`timescale 1ns/1ns

// Notes on behaviour
// (R1) high pin count: access strap high, store strobe low at reset release runs on-chip loader
// (R2) straps sampled only at reset release; they may go away afterwards
// (R3) outside party should release store strobe pin after reset rises
// (R4) low pin count factory setting: port one equal FEh forces on-chip loader
// (R5) user condition may sit on port one, three or four bits 0 and 1
// (R6) three non-volatile condition bytes, one per port, writable by software
// (R7) in-system programming starts at vector FF00h, bottom of loader flash
// (R8) programmed software vector starts user loader at vector byte then 00h
// (R9) firmware traffic only on control endpoint 0, 32 byte packets
// (R10) pll set so usb controller receives 48 MHz for any supported crystal
// (R11) crystals 6 to 48 MHz accepted in single and double speed modes; the code accepts only 6, 8, 12, 16, 20, 24, 32, 40 and 48 MHz
// (R12) programmed boot-jump fuse bit 6 maps boot area at F800h to FFFFh
// (R13) condition byte defaults FEh for port one, FFh for ports three and four
// (R14) no condition met: choose target from stored vector and status bytes
module bes_boot_entry_select #(
  parameter int PLL_LOCK_CYC = bes_pkg::BES_PLL_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic high_pin_count_i,
  input wire logic external_access_strap_i,
  input wire logic program_store_strobe_i,
  input wire logic [7:0] port_one_i,
  input wire logic [7:0] port_three_i,
  input wire logic [1:0] port_four_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic [15:0] boot_addr_o,
  output logic [1:0] boot_target_o,
  output logic boot_valid_o,
  output logic boot_map_o,
  output logic [15:0] boot_map_lo_o,
  output logic [15:0] boot_map_hi_o,
  output logic x2_mode_o,
  output logic [7:0] pll_mult_o,
  output logic [7:0] pll_div_o,
  output logic pll_en_o,
  output logic usb_clk_ok_o,
  output logic xtal_bad_o,
  output logic [3:0] usb_ep_o,
  output logic [7:0] usb_max_pkt_o
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  bes_pkg::bes_ports_t ports_s1_r;
  bes_pkg::bes_ports_t ports_s2_r;
  logic [1:0] strap_s1_r;
  logic [1:0] strap_s2_r;

  // two flops on every port pin before logic looks at it
  always_ff @(posedge clk_i) begin
    ports_s1_r <= {port_one_i, port_three_i, port_four_i};
    ports_s2_r <= ports_s1_r;
  end

  // straps get their own chain; no reset so they keep tracking through it
  always_ff @(posedge clk_i) begin
    strap_s1_r <= {external_access_strap_i, program_store_strobe_i};
    strap_s2_r <= strap_s1_r;
  end

  // ****************************************************************
  // configuration bytes
  // ****************************************************************
  logic [7:0] port_one_boot_cond_cfg_r;
  logic [7:0] port_three_boot_cond_cfg_r;
  logic [7:0] port_four_boot_cond_cfg_r;
  logic [7:0] software_boot_vector_r;
  logic [7:0] boot_status_r;
  logic [7:0] hw_byte_r;
  logic [7:0] xtal_mhz_r;

  // reset stands in for the non-volatile load; values hold until software rewrites them or the next reset reloads the defaults
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      port_one_boot_cond_cfg_r <= bes_pkg::BES_P1_CFG_RST; // [R13]
      port_three_boot_cond_cfg_r <= bes_pkg::BES_P3_CFG_RST; // [R13]
      port_four_boot_cond_cfg_r <= bes_pkg::BES_P4_CFG_RST; // [R13]
      software_boot_vector_r <= bes_pkg::BES_SBV_RST;
      boot_status_r <= bes_pkg::BES_BSB_RST;
      hw_byte_r <= bes_pkg::BES_HWB_RST;
      xtal_mhz_r <= bes_pkg::BES_XTAL_RST;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        bes_pkg::BES_REG_P1_CFG: port_one_boot_cond_cfg_r <= reg_wdata_i; // [R6]
        bes_pkg::BES_REG_P3_CFG: port_three_boot_cond_cfg_r <= reg_wdata_i; // [R6]
        bes_pkg::BES_REG_P4_CFG: port_four_boot_cond_cfg_r <= reg_wdata_i; // [R6]
        bes_pkg::BES_REG_SBV: software_boot_vector_r <= reg_wdata_i;
        bes_pkg::BES_REG_BSB: boot_status_r <= reg_wdata_i;
        bes_pkg::BES_REG_HWB: hw_byte_r <= reg_wdata_i;
        bes_pkg::BES_REG_XTAL: xtal_mhz_r <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // boot decision at reset release
  // ****************************************************************
  logic decided_r;
  logic cond_hit;
  logic hpc_hit;
  logic lpc_hit;
  logic [1:0] target_r;
  logic [15:0] addr_r;

  // straps: access high with strobe low; the strobe pin only matters at release [R1]
  assign hpc_hit = strap_s2_r[1] & ~strap_s2_r[0];

  // a port takes part when its byte is programmed (not FFh); port four uses two bits [R5]
  always_comb begin
    lpc_hit = 1'b0;
    if (port_one_boot_cond_cfg_r != 8'hFF &&
        ports_s2_r.port_one == port_one_boot_cond_cfg_r) begin
      lpc_hit = 1'b1; // [R4] [R5]
    end
    if (port_three_boot_cond_cfg_r != 8'hFF &&
        ports_s2_r.port_three == port_three_boot_cond_cfg_r) begin
      lpc_hit = 1'b1; // [R5]
    end
    if (port_four_boot_cond_cfg_r != 8'hFF &&
        ports_s2_r.port_four == (port_four_boot_cond_cfg_r[1:0] & bes_pkg::BES_P4_MASK)) begin
      lpc_hit = 1'b1; // [R5]
    end
  end

  assign cond_hit = high_pin_count_i ? hpc_hit : lpc_hit;

  // one decision per reset, taken on the first cycle after the sync chain settles;
  // later pin changes are ignored so the straps may be released [R2]
  logic [1:0] settle_r;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      settle_r <= 2'h0;
      decided_r <= 1'b0;
      target_r <= bes_pkg::BES_RUN_APP;
      addr_r <= bes_pkg::BES_APP_START;
    end else if (settle_r != bes_pkg::BES_SETTLE_CNT) begin
      settle_r <= settle_r + 2'h1;
    end else if (!decided_r) begin
      decided_r <= 1'b1; // [R2]
      if (cond_hit) begin
        target_r <= bes_pkg::BES_RUN_ISP; // [R1] [R4]
        addr_r <= {bes_pkg::BES_ISP_VEC_HI, bes_pkg::BES_VEC_LO}; // [R7]
      end else if (boot_status_r != 8'h00 || !hw_byte_r[bes_pkg::BES_FUSE_JUMP_BIT]) begin
        // regular flow: a clear status byte with fuse bit 6 high runs the application, otherwise
        // the vector picks the user loader unless it points into the boot area, F8h and up, which runs the on-chip one [R14]
        if (software_boot_vector_r == bes_pkg::BES_ISP_VEC_HI ||
            software_boot_vector_r >= bes_pkg::BES_BOOT_MAP_LO[15:8]) begin
          target_r <= bes_pkg::BES_RUN_ISP; // [R14]
          addr_r <= {bes_pkg::BES_ISP_VEC_HI, bes_pkg::BES_VEC_LO}; // [R7]
        end else begin
          target_r <= bes_pkg::BES_RUN_USER_BOOT; // [R14]
          addr_r <= {software_boot_vector_r, bes_pkg::BES_VEC_LO}; // [R8]
        end
      end else begin
        target_r <= bes_pkg::BES_RUN_APP; // [R14]
        addr_r <= bes_pkg::BES_APP_START;
      end
    end
  end

  assign boot_target_o = target_r;
  assign boot_addr_o = addr_r;
  assign boot_valid_o = decided_r;
  assign boot_map_lo_o = bes_pkg::BES_BOOT_MAP_LO;
  assign boot_map_hi_o = bes_pkg::BES_BOOT_MAP_HI;

  // programmed fuse (0) maps the loader area into code space; registered so the
  // outputs come straight from flops, at the price of one cycle after a write [R12]
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      boot_map_o <= ~bes_pkg::BES_HWB_RST[bes_pkg::BES_FUSE_JUMP_BIT];
      x2_mode_o <= ~bes_pkg::BES_HWB_RST[bes_pkg::BES_FUSE_X2_BIT];
    end else begin
      boot_map_o <= ~hw_byte_r[bes_pkg::BES_FUSE_JUMP_BIT]; // [R12]
      x2_mode_o <= ~hw_byte_r[bes_pkg::BES_FUSE_X2_BIT]; // [R11]
    end
  end

  // only the default control pipe carries upgrade traffic [R9]
  assign usb_ep_o = bes_pkg::BES_USB_EP; // [R9]
  assign usb_max_pkt_o = bes_pkg::BES_EP0_MAX_PKT; // [R9]

  // ****************************************************************
  // usb clock auto-configuration
  // ****************************************************************
  // pll out = xtal * mult / div; in double speed mode the core sees twice the
  // crystal rate but the pll still uses the crystal, so the setting is shared [R11]
  function automatic bes_pkg::bes_pll_t bes_pll_pick(input logic [7:0] mhz);
    bes_pkg::bes_pll_t p;
    p.mult = 8'h00;
    p.div = 8'h00;
    unique case (mhz)
      8'h06: begin
        p.mult = 8'h08;
        p.div = 8'h01;
      end
      8'h08: begin
        p.mult = 8'h06;
        p.div = 8'h01;
      end
      8'h0C: begin
        p.mult = 8'h04;
        p.div = 8'h01;
      end
      8'h10: begin
        p.mult = 8'h03;
        p.div = 8'h01;
      end
      8'h14: begin
        p.mult = 8'h0C;
        p.div = 8'h05;
      end
      8'h18: begin
        p.mult = 8'h02;
        p.div = 8'h01;
      end
      8'h20: begin
        p.mult = 8'h03;
        p.div = 8'h02;
      end
      8'h28: begin
        p.mult = 8'h06;
        p.div = 8'h05;
      end
      8'h30: begin
        p.mult = 8'h01;
        p.div = 8'h01;
      end
      default: ;
    endcase
    return p;
  endfunction : bes_pll_pick

  bes_pkg::bes_pll_t pll_set;
  logic [15:0] lock_cnt_r;
  logic [7:0] xtal_seen_r;

  assign pll_set = bes_pll_pick(xtal_mhz_r); // [R10] [R11]

  // restart the lock wait whenever the crystal setting changes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lock_cnt_r <= 16'h0000;
      xtal_seen_r <= 8'h00;
      pll_mult_o <= 8'h00;
      pll_div_o <= 8'h00;
      pll_en_o <= 1'b0;
      usb_clk_ok_o <= 1'b0;
      xtal_bad_o <= 1'b0;
    end else begin
      xtal_seen_r <= xtal_mhz_r;
      pll_mult_o <= pll_set.mult; // [R10]
      pll_div_o <= pll_set.div;
      pll_en_o <= (pll_set.mult != 8'h00);
      xtal_bad_o <= (pll_set.mult == 8'h00); // [R11]
      if (xtal_seen_r != xtal_mhz_r || pll_set.mult == 8'h00) begin
        lock_cnt_r <= 16'h0000;
        usb_clk_ok_o <= 1'b0;
      end else if (lock_cnt_r != 16'(PLL_LOCK_CYC)) begin
        lock_cnt_r <= lock_cnt_r + 16'h0001;
      end else begin
        usb_clk_ok_o <= 1'b1; // [R10]
      end
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  // data stand one cycle after the read strobe; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        bes_pkg::BES_REG_P1_CFG: reg_rdata_o <= port_one_boot_cond_cfg_r;
        bes_pkg::BES_REG_P3_CFG: reg_rdata_o <= port_three_boot_cond_cfg_r;
        bes_pkg::BES_REG_P4_CFG: reg_rdata_o <= port_four_boot_cond_cfg_r;
        bes_pkg::BES_REG_SBV: reg_rdata_o <= software_boot_vector_r;
        bes_pkg::BES_REG_BSB: reg_rdata_o <= boot_status_r;
        bes_pkg::BES_REG_HWB: reg_rdata_o <= hw_byte_r;
        bes_pkg::BES_REG_XTAL: reg_rdata_o <= xtal_mhz_r;
        bes_pkg::BES_REG_STATUS:
          reg_rdata_o <= {3'h0, xtal_bad_o, usb_clk_ok_o, decided_r, target_r};
        bes_pkg::BES_REG_VECTOR: reg_rdata_o <= addr_r[15:8];
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule : bes_boot_entry_select

/* verilog/bes_pkg.sv */
// package of constants and carriers for the boot entry select block
package bes_pkg;
  // ****************************************************************
  // configuration byte defaults and boot addresses
  // ****************************************************************
  localparam logic [7:0] BES_P1_CFG_RST = 8'hFE;
  localparam logic [7:0] BES_P3_CFG_RST = 8'hFF;
  localparam logic [7:0] BES_P4_CFG_RST = 8'hFF;
  localparam logic [7:0] BES_SBV_RST = 8'hFC;
  localparam logic [7:0] BES_BSB_RST = 8'hFF;
  localparam logic [7:0] BES_HWB_RST = 8'hBF;
  localparam logic [7:0] BES_XTAL_RST = 8'h0C;
  localparam logic [1:0] BES_SETTLE_CNT = 2'h3;
  localparam logic [7:0] BES_ISP_VEC_HI = 8'hFF;
  localparam logic [7:0] BES_VEC_LO = 8'h00;
  localparam logic [15:0] BES_BOOT_MAP_LO = 16'hF800;
  localparam logic [15:0] BES_BOOT_MAP_HI = 16'hFFFF;
  localparam logic [15:0] BES_APP_START = 16'h0000;
  localparam int BES_FUSE_JUMP_BIT = 6;
  localparam int BES_FUSE_X2_BIT = 7;
  localparam logic [1:0] BES_P4_MASK = 2'h3;
  // ****************************************************************
  // register map of the plain register port
  // ****************************************************************
  localparam logic [3:0] BES_REG_P1_CFG = 4'h0;
  localparam logic [3:0] BES_REG_P3_CFG = 4'h1;
  localparam logic [3:0] BES_REG_P4_CFG = 4'h2;
  localparam logic [3:0] BES_REG_SBV = 4'h3;
  localparam logic [3:0] BES_REG_BSB = 4'h4;
  localparam logic [3:0] BES_REG_HWB = 4'h5;
  localparam logic [3:0] BES_REG_XTAL = 4'h6;
  localparam logic [3:0] BES_REG_STATUS = 4'h7;
  localparam logic [3:0] BES_REG_VECTOR = 4'h8;
  // ****************************************************************
  // usb link and clock settings
  // ****************************************************************
  localparam logic [3:0] BES_USB_EP = 4'h0;
  localparam logic [7:0] BES_EP0_MAX_PKT = 8'h20;
  localparam int BES_USB_MHZ = 48;
  localparam int BES_PLL_CYC = 1000;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    BES_RUN_APP,
    BES_RUN_USER_BOOT,
    BES_RUN_ISP
  } bes_target_t;
  typedef struct packed {
    logic [7:0] port_one;
    logic [7:0] port_three;
    logic [1:0] port_four;
  } bes_ports_t;
  typedef struct packed {
    logic [7:0] mult;
    logic [7:0] div;
  } bes_pll_t;
endpackage : bes_pkg
